// file: design/error_loop_compensator_pwm.sv
// Rail voltage loop: error converter, reference slew, compensator, pulse engines
// Overview of operation
// - Sample error at software-chosen period instant
// - Error equals ten-bit reference minus sensed voltage
// - Gain codes 0-3 give gain 1/8,1/4,1/2,1
// - Gain code lives in each coefficient bank
// - Converter output clamps to -32 and 31
// - Slew reference toward sensed while saturated
// - Nonlinear gain, second-order then first-order IIR
// - Each rail has own state and coefficients
// - Bank 0 ramp, 1 regulate, 2 light load
// - Four limits pick region gain; below all: first
// - Nonsymmetric limits allowed; all-positive uses first gain
// - First-order section adds third zero and pole
// - Duty fraction times period gives threshold
// - Pulse high until counter reaches threshold
// - Engines lock to sync input, drive sync out
// - Sync rising edge restarts follower period counters
// - Sync word: upper byte driver, lower follower mask
`timescale 1ns/1ps
module error_loop_compensator_pwm #(
    parameter int NUM_RAILS = 2
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic [NUM_RAILS-1:0][10:0] sense_positive_pin_in,
    input wire logic [NUM_RAILS-1:0][10:0] sense_negative_pin_in,
    input wire logic [NUM_RAILS-1:0] ramp_active_in,
    input wire logic [NUM_RAILS-1:0][11:0] load_current_in,
    input wire logic sync_in,
    output logic sync_out,
    output logic [NUM_RAILS-1:0] pulse_width_output_out
);
    localparam int W = loop_pkg::WORD_W;
    localparam int COEF_WORDS = NUM_RAILS * loop_pkg::BANKS * loop_pkg::COEF_SLOTS;

    typedef struct packed {
        logic enable;
        logic [W-1:0] sync_cfg;
        logic [loop_pkg::CUR_W-1:0] light_thr;
        logic [NUM_RAILS-1:0][W-1:0] period;
        logic [NUM_RAILS-1:0][W-1:0] sample_at;
        logic [NUM_RAILS-1:0][loop_pkg::REF_W-1:0] ref_dac;
        logic [loop_pkg::SLEW_CNT_W-1:0] slew_cnt;
        logic [NUM_RAILS-1:0][1:0] bank;
        logic [NUM_RAILS-1:0][loop_pkg::ADC_W-1:0] adc;
        logic [NUM_RAILS-1:0] sat_pos;
        logic [NUM_RAILS-1:0] sat_neg;
        logic [NUM_RAILS-1:0] calc;
        logic [NUM_RAILS-1:0][W-1:0] x1;
        logic [NUM_RAILS-1:0][W-1:0] x2;
        logic [NUM_RAILS-1:0][W-1:0] y1;
        logic [NUM_RAILS-1:0][W-1:0] y2;
        logic [NUM_RAILS-1:0][W-1:0] z1;
        logic [NUM_RAILS-1:0][W-1:0] duty;
        logic sync_prev;
        logic sync_drive;
        logic [31:0] prdata;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic [W-1:0] coef_mem [COEF_WORDS];
    logic [NUM_RAILS-1:0][W-1:0] threshold;
    logic [NUM_RAILS-1:0] strobe;
    logic [NUM_RAILS-1:0] period_start;
    logic [NUM_RAILS-1:0] sync_reset;
    logic slew_tick;
    logic sync_rise;
    logic addr_hit;
    logic coef_hit;
    int coef_idx;
    int rail_idx;
    logic [31:0] rd_data;
    logic wr_en;

    if (NUM_RAILS < 1 || NUM_RAILS > loop_pkg::MAX_RAILS) begin : g_bad_rails
        $error("error_loop_compensator_pwm: NUM_RAILS out of range");
    end

    function automatic logic signed [39:0] mul(input logic signed [W-1:0] a,
                                               input logic signed [W-1:0] b);
        return 40'(a) * 40'(b);
    endfunction

    // Saturate instead of wrapping: a wrapped filter state would flip the loop
    function automatic logic signed [W-1:0] sat16(input logic signed [39:0] v);
        if (v > 40'sh00_0000_7fff) begin
            return 16'sh7fff;
        end
        if (v < 40'shff_ffff_8000) begin
            return 16'sh8000;
        end
        return v[W-1:0];
    endfunction

    function automatic logic signed [W-1:0] cf(input int idx);
        return $signed(coef_mem[idx]);
    endfunction

    // ==================================================
    // APB address decode and read data
    always_comb begin
        addr_hit = 1'b1;
        coef_hit = 1'b0;
        coef_idx = 0;
        rail_idx = 0;
        rd_data = '0;
        if (paddr_in[1:0] != 2'h0) begin
            addr_hit = 1'b0;
        end else if (paddr_in >= loop_pkg::COEF_BASE &&
                     paddr_in < loop_pkg::COEF_BASE + 12'(COEF_WORDS * 4)) begin
            coef_hit = 1'b1;
            coef_idx = int'((paddr_in - loop_pkg::COEF_BASE) >> 2);
            rd_data = {16'h0000, coef_mem[coef_idx]};
        end else if (paddr_in >= loop_pkg::RAIL_BASE &&
                     paddr_in < loop_pkg::RAIL_BASE + 12'(NUM_RAILS * loop_pkg::RAIL_STRIDE)) begin
            rail_idx = int'((paddr_in - loop_pkg::RAIL_BASE) >> 4);
            case (paddr_in[3:0])
                loop_pkg::PERIOD_OFS: rd_data = {16'h0000, s_q.period[rail_idx]};
                loop_pkg::SAMPLE_OFS: rd_data = {16'h0000, s_q.sample_at[rail_idx]};
                loop_pkg::REF_OFS: rd_data = {22'h00_0000, s_q.ref_dac[rail_idx]};
                loop_pkg::DUTY_OFS: rd_data = {16'h0000, s_q.duty[rail_idx]};
                default: addr_hit = 1'b0;
            endcase
        end else begin
            case (paddr_in)
                loop_pkg::CTRL_ADDR: rd_data[loop_pkg::CTRL_ENABLE] = s_q.enable;
                loop_pkg::SYNC_ADDR: rd_data = {16'h0000, s_q.sync_cfg};
                loop_pkg::LIGHT_ADDR: rd_data = {20'h0_0000, s_q.light_thr};
                loop_pkg::STATUS_ADDR: begin
                    for (int r = 0; r < NUM_RAILS; r++) begin
                        rd_data[loop_pkg::ST_SAT_POS + r] = s_q.sat_pos[r];
                        rd_data[loop_pkg::ST_SAT_NEG + r] = s_q.sat_neg[r];
                        rd_data[loop_pkg::ST_BANK + 2 * r +: 2] = s_q.bank[r];
                    end
                end
                default: addr_hit = 1'b0;
            endcase
        end
    end

    // Zero-wait slave; errors only flagged in the access phase
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in && penable_in && !addr_hit;
    assign prdata_out = s_q.prdata;
    assign wr_en = psel_in && penable_in && pwrite_in && addr_hit;

    // ==================================================
    // Coefficient store, one word per slot, per rail and bank
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            for (int i = 0; i < COEF_WORDS; i++) begin
                coef_mem[i] <= '0;
            end
        end else if (wr_en && coef_hit) begin
            coef_mem[coef_idx] <= pwdata_in[W-1:0];
        end
    end

    // ==================================================
    // Slew divider and sync edge
    assign slew_tick = (s_q.slew_cnt == loop_pkg::SLEW_CNT_W'(loop_pkg::SLEW_STEP_CYCLES - 1));
    assign sync_rise = sync_in && !s_q.sync_prev;

    // ==================================================
    // Loop state update
    always_comb begin
        logic signed [12:0] sensed;
        logic signed [13:0] err;
        logic signed [13:0] scaled;
        logic [1:0] nb;
        logic [2:0] region;
        logic signed [W-1:0] e16;
        logic signed [W-1:0] x;
        logic signed [W-1:0] y;
        logic signed [W-1:0] z;
        logic signed [39:0] acc;
        int base;
        int nbase;
        sensed = '0;
        err = '0;
        scaled = '0;
        nb = '0;
        region = '0;
        e16 = '0;
        x = '0;
        y = '0;
        z = '0;
        acc = '0;
        base = 0;
        nbase = 0;
        s_d = s_q;
        s_d.sync_prev = sync_in;
        s_d.slew_cnt = slew_tick ? '0 : s_q.slew_cnt + 1'b1;
        // Read data captured in setup so it stands through the access phase
        if (psel_in && !penable_in && !pwrite_in) begin
            s_d.prdata = rd_data;
        end
        // Sync output follows the selected rail's period start
        s_d.sync_drive = 1'b0;
        if (s_q.sync_cfg[loop_pkg::SYNC_OUT_LSB +: 8] < 8'(NUM_RAILS)) begin
            s_d.sync_drive = period_start[int'(s_q.sync_cfg[loop_pkg::SYNC_OUT_LSB +: 8])];
        end
        for (int r = 0; r < NUM_RAILS; r++) begin
            nb = ramp_active_in[r] ? loop_pkg::BANK_RAMP :
                 (load_current_in[r] < s_q.light_thr) ? loop_pkg::BANK_LIGHT :
                 loop_pkg::BANK_REGULATE;
            nbase = (r * loop_pkg::BANKS + int'(nb)) * loop_pkg::COEF_SLOTS;
            base = (r * loop_pkg::BANKS + int'(s_q.bank[r])) * loop_pkg::COEF_SLOTS;
            s_d.calc[r] = 1'b0;
            // Reference slews toward the sense level one LSB per divider tick
            if (slew_tick && s_q.enable) begin
                if (s_q.sat_pos[r] && s_q.ref_dac[r] != '0) begin
                    s_d.ref_dac[r] = s_q.ref_dac[r] - 1'b1;
                end else if (s_q.sat_neg[r] && s_q.ref_dac[r] != '1) begin
                    s_d.ref_dac[r] = s_q.ref_dac[r] + 1'b1;
                end
            end
            // Sample: form, scale and clamp the error; latch bank at this boundary
            if (strobe[r]) begin
                sensed = $signed({2'b00, sense_positive_pin_in[r]}) -
                         $signed({2'b00, sense_negative_pin_in[r]});
                err = $signed({4'h0, s_q.ref_dac[r]}) - 14'(sensed);
                scaled = err >>> (loop_pkg::GAIN_SHIFT_MAX -
                                  int'(coef_mem[nbase + loop_pkg::CI_GAIN_CODE][1:0]));
                s_d.sat_pos[r] = scaled > 14'(loop_pkg::ADC_MAX);
                s_d.sat_neg[r] = scaled < 14'(loop_pkg::ADC_MIN);
                s_d.adc[r] = s_d.sat_pos[r] ? loop_pkg::ADC_MAX :
                             s_d.sat_neg[r] ? loop_pkg::ADC_MIN : scaled[5:0];
                s_d.bank[r] = nb;
                s_d.calc[r] = 1'b1;
            end
            // Compute: nonlinear gain, biquad, then first-order section
            if (s_q.calc[r]) begin
                e16 = 16'($signed(s_q.adc[r]));
                region = '0;
                for (int k = 0; k < loop_pkg::NUM_LIMITS; k++) begin
                    if (e16 >= cf(base + loop_pkg::CI_LIMIT + k)) begin
                        region = region + 3'h1;
                    end
                end
                x = sat16(mul(e16, cf(base + loop_pkg::CI_NL_GAIN + int'(region))));
                acc = mul(cf(base + loop_pkg::CI_B0), x) +
                      mul(cf(base + loop_pkg::CI_B1), $signed(s_q.x1[r])) +
                      mul(cf(base + loop_pkg::CI_B2), $signed(s_q.x2[r])) -
                      mul(cf(base + loop_pkg::CI_A1), $signed(s_q.y1[r])) -
                      mul(cf(base + loop_pkg::CI_A2), $signed(s_q.y2[r]));
                y = sat16(acc >>> loop_pkg::FILT_FRAC);
                acc = mul(cf(base + loop_pkg::CI_C0), y) +
                      mul(cf(base + loop_pkg::CI_C1), $signed(s_q.y1[r])) -
                      mul(cf(base + loop_pkg::CI_D1), $signed(s_q.z1[r]));
                z = sat16(acc >>> loop_pkg::FILT_FRAC);
                s_d.x2[r] = s_q.x1[r];
                s_d.x1[r] = x;
                s_d.y2[r] = s_q.y1[r];
                s_d.y1[r] = y;
                s_d.z1[r] = z;
                // Negative clamps to 0 %, full scale counts as 100 %
                if (z < 0) begin
                    s_d.duty[r] = '0;
                end else if (z == 16'sh7fff) begin
                    s_d.duty[r] = loop_pkg::DUTY_ONE;
                end else begin
                    s_d.duty[r] = z;
                end
            end
        end
        // Register writes
        if (wr_en && !coef_hit) begin
            if (paddr_in >= loop_pkg::RAIL_BASE && paddr_in < loop_pkg::COEF_BASE) begin
                case (paddr_in[3:0])
                    loop_pkg::PERIOD_OFS: s_d.period[rail_idx] = pwdata_in[W-1:0];
                    loop_pkg::SAMPLE_OFS: s_d.sample_at[rail_idx] = pwdata_in[W-1:0];
                    loop_pkg::REF_OFS: s_d.ref_dac[rail_idx] = pwdata_in[loop_pkg::REF_W-1:0];
                    default: ;
                endcase
            end else begin
                case (paddr_in)
                    loop_pkg::CTRL_ADDR: s_d.enable = pwdata_in[loop_pkg::CTRL_ENABLE];
                    loop_pkg::SYNC_ADDR: s_d.sync_cfg = pwdata_in[W-1:0];
                    loop_pkg::LIGHT_ADDR: s_d.light_thr = pwdata_in[loop_pkg::CUR_W-1:0];
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_q <= '0;
            s_q.sync_cfg <= loop_pkg::SYNC_RST;
            s_q.light_thr <= loop_pkg::LIGHT_RST;
            for (int r = 0; r < NUM_RAILS; r++) begin
                s_q.period[r] <= loop_pkg::PERIOD_RST;
                s_q.sample_at[r] <= loop_pkg::SAMPLE_RST;
                s_q.bank[r] <= loop_pkg::BANK_RAMP;
            end
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.sync_drive;

    // ==================================================
    // One pulse engine per rail
    for (genvar r = 0; r < NUM_RAILS; r++) begin : g_rail
        assign threshold[r] = W'((32'(s_q.duty[r]) * 32'(s_q.period[r])) >> loop_pkg::DUTY_FRAC);
        assign sync_reset[r] = sync_rise && s_q.sync_cfg[r];
        pulse_engine #(
            .CNT_W(W)
        ) u_engine (
            .clk_in(clk_in),
            .reset_n_in(reset_n_in),
            .enable_in(s_q.enable),
            .period_in(s_q.period[r]),
            .threshold_in(threshold[r]),
            .sample_at_in(s_q.sample_at[r]),
            .sync_reset_in(sync_reset[r]),
            .pwm_out(pulse_width_output_out[r]),
            .period_start_out(period_start[r]),
            .sample_strobe_out(strobe[r])
        );
    end

    // ==================================================
    // Checks on rail 0 and on sync out
    a_clamp_high_code: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        s_q.sat_pos[0] |-> $signed(s_q.adc[0]) == 31)
        else $error("positive clamp code wrong");
    a_clamp_low_code: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        s_q.sat_neg[0] |-> $signed(s_q.adc[0]) == -32)
        else $error("negative clamp code wrong");
    a_slew_down_step: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        slew_tick && s_q.enable && s_q.sat_pos[0] && s_q.ref_dac[0] != '0 && !wr_en
        |=> s_q.ref_dac[0] == $past(s_q.ref_dac[0]) - 1'b1)
        else $error("reference did not step down");
    a_bank_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !strobe[0] |=> $stable(s_q.bank[0]))
        else $error("bank changed between samples");
    a_bank_ramp: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        strobe[0] && ramp_active_in[0] |=> s_q.bank[0] == loop_pkg::BANK_RAMP)
        else $error("ramp bank not chosen");
    a_sample_compute: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        strobe[0] |=> s_q.calc[0] ##1 !s_q.calc[0] || strobe[0])
        else $error("sample not followed by compute");
    a_duty_range: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        s_q.duty[0] <= loop_pkg::DUTY_ONE)
        else $error("duty above full scale");
    a_sync_out_off: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        s_q.sync_cfg[15:8] >= 8'(NUM_RAILS) |=> !sync_out)
        else $error("sync out driven while disabled");
endmodule

// file: include/loop_pkg.sv
// Shared constants for the rail error loop, compensator and pulse engines
package loop_pkg;
    // ==================================================
    // Clock and slew timing
    localparam int CLK_HZ = 125_000_000;
    localparam real SLEW_V_PER_MS = 0.156;
    localparam real DAC_LSB_V = 0.001;
    // Longest spacing between one-LSB reference steps, rounded down
    localparam int SLEW_STEP_CYCLES =
        int'($floor(DAC_LSB_V / SLEW_V_PER_MS * real'(CLK_HZ / 1000)));
    localparam int SLEW_CNT_W = 10;

    // ==================================================
    // Datapath widths and limits
    localparam int REF_W = 10;
    localparam int SENSE_W = 11;
    localparam int ADC_W = 6;
    localparam int CUR_W = 12;
    localparam int WORD_W = 16;
    localparam logic signed [ADC_W-1:0] ADC_MIN = 6'sh20;
    localparam logic signed [ADC_W-1:0] ADC_MAX = 6'sh1f;
    localparam int GAIN_SHIFT_MAX = 3;
    localparam int FILT_FRAC = 14;
    localparam int DUTY_FRAC = 15;
    localparam logic [WORD_W-1:0] DUTY_ONE = 16'h8000;
    localparam int MAX_RAILS = 4;

    // ==================================================
    // Coefficient banks and slot layout within one bank
    localparam int BANKS = 3;
    localparam int COEF_SLOTS = 32;
    localparam logic [1:0] BANK_RAMP = 2'h0;
    localparam logic [1:0] BANK_REGULATE = 2'h1;
    localparam logic [1:0] BANK_LIGHT = 2'h2;
    localparam int CI_GAIN_CODE = 0;
    localparam int CI_LIMIT = 1;
    localparam int NUM_LIMITS = 4;
    localparam int CI_NL_GAIN = 5;
    localparam int CI_B0 = 10;
    localparam int CI_B1 = 11;
    localparam int CI_B2 = 12;
    localparam int CI_A1 = 13;
    localparam int CI_A2 = 14;
    localparam int CI_C0 = 15;
    localparam int CI_C1 = 16;
    localparam int CI_D1 = 17;

    // ==================================================
    // Register map (byte addresses)
    localparam int ADDR_W = 12;
    localparam logic [11:0] CTRL_ADDR = 12'h000;
    localparam logic [11:0] SYNC_ADDR = 12'h004;
    localparam logic [11:0] LIGHT_ADDR = 12'h008;
    localparam logic [11:0] STATUS_ADDR = 12'h00c;
    localparam logic [11:0] RAIL_BASE = 12'h010;
    localparam int RAIL_STRIDE = 16;
    localparam logic [3:0] PERIOD_OFS = 4'h0;
    localparam logic [3:0] SAMPLE_OFS = 4'h4;
    localparam logic [3:0] REF_OFS = 4'h8;
    localparam logic [3:0] DUTY_OFS = 4'hc;
    localparam logic [11:0] COEF_BASE = 12'h400;

    // ==================================================
    // Field positions and reset values
    localparam int CTRL_ENABLE = 0;
    localparam int SYNC_OUT_LSB = 8;
    localparam int ST_SAT_POS = 0;
    localparam int ST_SAT_NEG = 4;
    localparam int ST_BANK = 8;
    localparam logic [WORD_W-1:0] PERIOD_RST = 16'h0100;
    localparam logic [WORD_W-1:0] SAMPLE_RST = 16'h0080;
    localparam logic [WORD_W-1:0] SYNC_RST = 16'hff00;
    localparam logic [CUR_W-1:0] LIGHT_RST = 12'h000;
endpackage

// file: design/pulse_engine.sv
// Per-rail counter-compare pulse engine with sync restart
`timescale 1ns/1ps
module pulse_engine #(
    parameter int CNT_W = 16
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic enable_in,
    input wire logic [CNT_W-1:0] period_in,
    input wire logic [CNT_W-1:0] threshold_in,
    input wire logic [CNT_W-1:0] sample_at_in,
    input wire logic sync_reset_in,
    output logic pwm_out,
    output logic period_start_out,
    output logic sample_strobe_out
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] thr;
        logic pwm;
    } engine_t;

    engine_t s_q;
    engine_t s_d;
    logic [CNT_W-1:0] last;

    if (CNT_W < 2) begin : g_bad_width
        $error("pulse_engine: counter width too small");
    end

    // ==================================================
    // Period counter and compare
    // Threshold is taken only at period start so a pulse never glitches mid-period
    always_comb begin
        s_d = s_q;
        last = (period_in == '0) ? '0 : period_in - 1'b1;
        if (!enable_in || sync_reset_in) begin
            s_d.cnt = '0;
        end else if (s_q.cnt >= last) begin
            s_d.cnt = '0;
        end else begin
            s_d.cnt = s_q.cnt + 1'b1;
        end
        if (s_d.cnt == '0) begin
            s_d.thr = threshold_in;
        end
        s_d.pwm = enable_in && (s_d.cnt < s_d.thr);
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Strobes are combinational, pulse comes from a flop
    assign pwm_out = s_q.pwm;
    assign period_start_out = enable_in && (s_q.cnt == '0);
    assign sample_strobe_out = enable_in && (s_q.cnt == sample_at_in);

    // ==================================================
    // Checks
    a_sync_restart: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        enable_in && sync_reset_in |=> s_q.cnt == '0)
        else $error("counter not restarted by sync");
    a_count_wrap: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        enable_in && !sync_reset_in && s_q.cnt >= last |=> s_q.cnt == '0)
        else $error("counter did not wrap at period end");
    a_pulse_ends: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        s_q.cnt >= s_q.thr |-> !pwm_out)
        else $error("pulse high past threshold");
endmodule

// file: sim/power_stage_model.sv
// Behavioural power stage and sensed output for each rail
`timescale 1ns/1ps
module power_stage_model #(
    parameter int N = 2
) (
    input wire logic clk_in,
    input wire logic [N-1:0] pulse_in,
    input wire logic [10:0] base_in,
    output logic [N-1:0][10:0] pos_out,
    output logic [N-1:0][10:0] neg_out
);
    // ==============================
    // Output charge: rises while the gate is driven, sags otherwise
    logic [N-1:0][7:0] lvl_q = '0;
    always @(posedge clk_in) begin
        for (int r = 0; r < N; r++) begin
            if (pulse_in[r] && lvl_q[r] != 8'hff) lvl_q[r] <= lvl_q[r] + 8'h01;
            else if (!pulse_in[r] && lvl_q[r] != 8'h00) lvl_q[r] <= lvl_q[r] - 8'h01;
        end
    end
    // Return side sits a little above ground, so the difference matters
    always_comb begin
        for (int r = 0; r < N; r++) begin
            pos_out[r] = base_in + {3'h0, lvl_q[r]} + 11'h002;
            neg_out[r] = 11'h002;
        end
    end
endmodule

// file: sim/error_loop_compensator_pwm_tb_top.sv
// Self-checking bench for the rail loop compensator
`timescale 1ns/1ps
module error_loop_compensator_pwm_tb_top;
    logic clk_in = 0, reset_n_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0, sync_in = 0;
    logic [11:0] paddr_in = '0, lim = 12'h100;
    logic [31:0] pwdata_in = '0, prdata_out, rd, r, seed = 32'hf294_5bf6;
    logic pready_out, pslverr_out, sync_out, err;
    logic [1:0] ramp_active_in = '0, pulse_width_output_out;
    logic [1:0][11:0] load_current_in = '0;
    logic [1:0][10:0] pos, neg;
    logic [10:0] base = 11'h000;
    int bad_count = 0, n_checks = 0, cyc = 0, k, e;
    // Bank 0 slots 0..15: gain code, limits, region gains, unity b0 and c0
    int coefv [16] = '{3, -8, -2, 2, 8, 1, 2, 3, 4, 5, 16384, 0, 0, 0, 0, 16384};
    error_loop_compensator_pwm #(.NUM_RAILS(2)) u_error_loop_compensator_pwm (.clk_in(clk_in),
        .reset_n_in(reset_n_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .sense_positive_pin_in(pos), .sense_negative_pin_in(neg),
        .ramp_active_in(ramp_active_in), .load_current_in(load_current_in), .sync_in(sync_in),
        .sync_out(sync_out), .pulse_width_output_out(pulse_width_output_out));
    power_stage_model #(.N(2)) u_power_stage_model (.clk_in(clk_in),
        .pulse_in(pulse_width_output_out), .base_in(base), .pos_out(pos), .neg_out(neg));
    // ==============================
    // Clock and hang guard
    initial forever #4 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            end_sim();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [1:0] exp_bank(input logic ramp, input logic [11:0] cur);
        return ramp ? 2'h0 : (cur < lim ? 2'h2 : 2'h1);
    endfunction
    // Unity filters: duty is error times the gain of its region, floored at 0
    function automatic logic [31:0] exp_duty(input int v);
        int g = 5;
        for (int j = 1; j < 5; j++) if (v < coefv[j]) g--;
        return (v < 0) ? '0 : 32'(v * coefv[4 + g]);
    endfunction
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    // One APB transfer; holds the request until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do @(posedge clk_in); while (pready_out !== 1'b1);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic wait_sync(output int n);
        n = 0;
        do begin
            @(negedge clk_in);
            n++;
        end while (sync_out !== 1'b1);
    endtask
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ==============================
    // Main sequence
    initial begin
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        apb(0, loop_pkg::SYNC_ADDR, 0);
        chk("sync word", rd, 32'h0000_ff00);
        apb(0, 12'h014, 0);
        chk("sample instant", rd, 32'h0000_0080);
        apb(0, 12'h0ff, 0);
        chk("refused access", {31'h0, err}, 32'h0000_0001);
        r = 32'h0000_0090 + {25'h0, seed[6:0]};
        apb(1, 12'h020, r);
        apb(0, 12'h020, 0);
        chk("period", rd, r);
        $display("test registers done");
        apb(1, loop_pkg::CTRL_ADDR, 1);
        k = 0;
        repeat (600) begin
            @(negedge clk_in);
            if (pulse_width_output_out !== 2'b00) k++;
        end
        chk("zero duty highs", k, 0);
        apb(1, loop_pkg::SYNC_ADDR, 32'h0000_0001);
        wait_sync(k);
        wait_sync(k);
        chk("sync spacing", k, 256);
        @(posedge clk_in);
        sync_in <= 1'b1;
        wait_sync(k);
        chk("sync restart", k, 3);
        @(posedge clk_in) sync_in <= 1'b0;
        $display("test pulse and sync done");
        apb(1, loop_pkg::LIGHT_ADDR, {20'h0, lim});
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            ramp_active_in <= (i == 0) ? 2'b00 : seed[1:0];
            load_current_in <= (i == 0) ? {lim, lim - 12'h001} : {seed[27:16], seed[11:0]};
            repeat (600) @(posedge clk_in);
            apb(0, loop_pkg::STATUS_ADDR, 0);
            chk("bank", rd[11:8], {exp_bank(ramp_active_in[1], load_current_in[1]),
                exp_bank(ramp_active_in[0], load_current_in[0])});
        end
        ramp_active_in <= 2'b11;
        for (int s = 0; s < 16; s++) apb(1, 12'h400 + 12'(4 * s), coefv[s]);
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            e = int'(seed[4:0]) - 12;
            apb(1, 12'h018, 32'(256 + e));
            base <= 11'h100;
            repeat (600) @(posedge clk_in);
            apb(0, 12'h01c, 0);
            chk("duty", rd, exp_duty(e));
        end
        $display("test banks and gains done");
        seed = lfsr(seed);
        r = {23'h0, seed[8:0]};
        apb(1, 12'h018, r);
        apb(0, 12'h018, 0);
        chk("reference", rd, r);
        base <= r[10:0] + 11'h1f4;
        repeat (600) @(posedge clk_in);
        apb(0, loop_pkg::STATUS_ADDR, 0);
        chk("clamp flags", {30'h0, rd[4], rd[0]}, 32'h0000_0002);
        repeat (1800) @(posedge clk_in);
        apb(0, 12'h018, 0);
        chk("slew toward sense", {31'h0, rd > r}, 32'h0000_0001);
        apb(1, 12'h018, 32'h0000_03ff);
        base <= 11'h000;
        repeat (2400) @(posedge clk_in);
        apb(0, loop_pkg::STATUS_ADDR, 0);
        chk("high clamp", {31'h0, rd[0]}, 32'h0000_0001);
        apb(0, 12'h018, 0);
        chk("slew down", {31'h0, rd < 32'h0000_03ff}, 32'h0000_0001);
        $display("test saturation done");
        end_sim();
    end
endmodule
